// *** core/acs_cal_sequencer.v ***
// calibration sequencer of a sigma-delta converter
// Contract
// - calibration starts on strobe falling edge, never earlier.
// - select inputs sampled at start choose calibration type.
// - selects 00: self calibration, 3,145,655 cycles.
// - selects 11: system offset first step, 1,052,599 cycles.
// - select a low, b high: system gain second step, 1,068,813 cycles.
// - select a high, b low: one-step system offset, 2,117,389 cycles.
// - bipolar mode calibrates positive full scale and midscale.
// - data-ready stays high throughout any calibration.
// - after self calibration, data-ready only once input has settled.
// - after other types, data-ready allowed as settling begins.
// - new unread word: data-ready high four cycles, then low.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"
module acs_cal_sequencer
#(
   parameter CNT_W = 22,
   parameter [CNT_W-1:0] CYC_SELF = `ACS_CYC_SELF,
   parameter [CNT_W-1:0] CYC_SYS_OFS = `ACS_CYC_SYS_OFS,
   parameter [CNT_W-1:0] CYC_SYS_GAIN = `ACS_CYC_SYS_GAIN,
   parameter [CNT_W-1:0] CYC_OFS_ONE = `ACS_CYC_OFS_ONE,
   parameter [CNT_W-1:0] CYC_SETTLE = `ACS_SETTLE_CYC
)
(
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // calibration control pins
   input wire cal_strobe,
   input wire cal_select_a,
   input wire cal_select_b,
   // converter configuration and data path
   input wire bipolar_mode,
   input wire word_load,
   input wire word_read,
   // calibration engine steering
   output reg cal_active,
   output reg [1:0] cal_type,
   output reg cal_zero_from_input,
   output reg cal_fs_from_input,
   output reg cal_midscale,
   // data ready pin
   output reg data_ready_n
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_CAL = 4'h2;
   localparam [3:0] ST_SETTLE = 4'h4;
   localparam [3:0] ST_RUN = 4'h8;

   function [CNT_W-1:0] cal_len;
      input [1:0] sel;
      begin
         case (sel)
            `ACS_SEL_SELF: cal_len = CYC_SELF;
            `ACS_SEL_SYS_OFS: cal_len = CYC_SYS_OFS;
            `ACS_SEL_SYS_GAIN: cal_len = CYC_SYS_GAIN;
            default: cal_len = CYC_OFS_ONE;
         endcase
      end
   endfunction

   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [2:0] pulse_cnt_r;
   reg word_pending_r;
   reg cnt_load;
   reg [CNT_W-1:0] cnt_val;
   wire cal_start;
   wire cnt_busy;
   wire cnt_done;
   wire [1:0] sel_now;

   assign sel_now = {cal_select_a, cal_select_b};

   acs_strobe_detect u_strobe
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .cal_strobe(cal_strobe),
      .cal_start(cal_start)
   );

   acs_counter #(.W(CNT_W)) u_cnt
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(cnt_load),
      .load_val(cnt_val),
      .busy(cnt_busy),
      .done(cnt_done)
   );

   always @*
   begin
      state_nxt = state_r;
      cnt_load = 1'b0;
      cnt_val = cal_len(sel_now);
      case (state_r)
         ST_IDLE, ST_RUN:
         begin
            if (cal_start)
            begin
               state_nxt = ST_CAL;
               cnt_load = 1'b1;
            end
         end
         ST_CAL:
         begin
            // strobe and selects are not looked at here
            // an idle counter here would hang the cycle, so leave as if done
            if (cnt_done || !cnt_busy)
            begin
               if (cal_type == `ACS_SEL_SELF)
               begin
                  state_nxt = ST_SETTLE;
                  cnt_load = 1'b1;
                  cnt_val = CYC_SETTLE;
               end
               else
                  state_nxt = ST_RUN;
            end
         end
         ST_SETTLE:
         begin
            if (cnt_done)
               state_nxt = ST_RUN;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         cal_active <= 1'b0;
         cal_type <= 2'h0;
         cal_zero_from_input <= 1'b0;
         cal_fs_from_input <= 1'b0;
         cal_midscale <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cal_active <= (state_nxt == ST_CAL);
         if (cnt_load && state_r != ST_CAL)
         begin
            cal_type <= sel_now;
            cal_zero_from_input <= cal_select_a;
            cal_fs_from_input <= ~cal_select_a & cal_select_b;
            cal_midscale <= bipolar_mode;
         end
      end
   end

   // data ready: high during calibration, 4-cycle high blip on new unread word
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         data_ready_n <= 1'b1;
         pulse_cnt_r <= 3'h0;
         word_pending_r <= 1'b0;
      end
      else if (state_nxt != ST_RUN)
      begin
         data_ready_n <= 1'b1;
         pulse_cnt_r <= 3'h0;
         word_pending_r <= 1'b0;
      end
      else if (word_load)
      begin
         data_ready_n <= 1'b1;
         pulse_cnt_r <= `ACS_DATA_READY_N_PULSE - 3'h1;
         word_pending_r <= 1'b1;
      end
      else if (pulse_cnt_r != 3'h0)
      begin
         pulse_cnt_r <= pulse_cnt_r - 3'h1;
         data_ready_n <= 1'b1;
      end
      else if (state_r != ST_RUN)
      begin
         data_ready_n <= 1'b0;
         word_pending_r <= 1'b1;
      end
      else if (word_read)
      begin
         data_ready_n <= 1'b1;
         word_pending_r <= 1'b0;
      end
      else
         data_ready_n <= ~word_pending_r;
   end
endmodule // acs_cal_sequencer
`default_nettype wire

// *** core/acs_counter.v ***
// loadable down counter with terminal flag
`timescale 1ns/1ps
`default_nettype none
module acs_counter
#(
   parameter W = 22
)
(
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // load and status
   input wire load,
   input wire [W-1:0] load_val,
   output wire busy,
   output wire done
);
   reg [W-1:0] cnt_r;
   always @(posedge clk_sys)
   begin
      if (rst)
         cnt_r <= {W{1'b0}};
      else if (load)
         cnt_r <= load_val;
      else if (cnt_r != {W{1'b0}})
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
   end
   assign busy = (cnt_r != {W{1'b0}});
   assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule // acs_counter
`default_nettype wire

// *** core/acs_defines.vh ***
// constants of the calibration sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_CYC_SELF 22'h2FFFB7
`define ACS_CYC_SYS_OFS 22'h100FB7
`define ACS_CYC_SYS_GAIN 22'h104F0D
`define ACS_CYC_OFS_ONE 22'h204F0D
`define ACS_CAL_HIGH_MIN 3'h4
`define ACS_DATA_READY_N_PULSE 3'h4
`define ACS_SETTLE_CYC 22'h07C000
`define ACS_SEL_SELF 2'h0
`define ACS_SEL_SYS_OFS 2'h3
`define ACS_SEL_SYS_GAIN 2'h1
`define ACS_SEL_OFS_ONE 2'h2
`endif

// *** core/acs_strobe_detect.v ***
// calibration strobe qualifier: high for at least four cycles, then falling edge
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"
module acs_strobe_detect
(
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // strobe in, start out
   input wire cal_strobe,
   output wire cal_start
);
   reg [2:0] high_cnt_r;
   reg strobe_r;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         high_cnt_r <= 3'h0;
         strobe_r <= 1'b0;
      end
      else
      begin
         strobe_r <= cal_strobe;
         if (!cal_strobe)
            high_cnt_r <= 3'h0;
         else if (high_cnt_r != `ACS_CAL_HIGH_MIN)
            high_cnt_r <= high_cnt_r + 3'h1;
      end
   end
   // falling edge after a long enough high phase
   assign cal_start = strobe_r & ~cal_strobe & (high_cnt_r == `ACS_CAL_HIGH_MIN);
endmodule // acs_strobe_detect
`default_nettype wire

// *** dv/acs_cal_properties.sv ***
// property checker of the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_chk
#(
   parameter [21:0] CYC_SELF = 22'h14
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pins
   input wire logic cal_strobe,
   input wire logic cal_select_a,
   input wire logic cal_select_b,
   input wire logic bipolar_mode,
   input wire logic cal_active,
   input wire logic [1:0] cal_type,
   input wire logic cal_midscale,
   input wire logic data_ready_n
);
   localparam int S = CYC_SELF - 1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_start;
      $rose(cal_active) |-> !$past(cal_strobe) && $past(cal_strobe, 2) && $past(cal_strobe, 5);
   endproperty
   property p_type;
      $rose(cal_active) |-> cal_type == {$past(cal_select_a), $past(cal_select_b)};
   endproperty
   property p_mid;
      $rose(cal_active) |-> cal_midscale == $past(bipolar_mode);
   endproperty
   property p_data_ready_n;
      cal_active |-> data_ready_n;
   endproperty
   property p_hold;
      $past(cal_active) && cal_active |-> $stable(cal_type) && $stable(cal_midscale);
   endproperty
   property p_len;
      $rose(cal_active) && cal_type == 2'h0 |-> ##S cal_active ##1 !cal_active;
   endproperty
   property p_settle;
      $fell(cal_active) && cal_type == 2'h0 |-> data_ready_n [*8];
   endproperty
   property p_early;
      $fell(cal_active) && cal_type != 2'h0 |-> !data_ready_n;
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   a_type: assert property (p_type) else $error("bad type");
   a_mid: assert property (p_mid) else $error("bad midscale");
   a_data_ready_n: assert property (p_data_ready_n) else $error("ready in cal");
   a_hold: assert property (p_hold) else $error("type moved");
   a_len: assert property (p_len) else $error("bad self length");
   a_settle: assert property (p_settle) else $error("early ready");
   a_early: assert property (p_early) else $error("late ready");
   c_ofs: cover property ($rose(cal_active) && cal_type == 2'h3);
   c_gain: cover property ($rose(cal_active) && cal_type == 2'h1);
   c_self: cover property ($fell(cal_active) && cal_type == 2'h0);
endmodule // acs_chk
bind acs_cal_sequencer acs_chk #(.CYC_SELF(CYC_SELF)) u_chk(.clk_sys, .rst, .cal_strobe,
   .cal_select_a, .cal_select_b, .bipolar_mode, .cal_active, .cal_type, .cal_midscale,
   .data_ready_n);
`default_nettype wire

// *** dv/acs_cal_sequencer_tb.sv ***
// self-checking bench of the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_cal_sequencer_tb;
   logic clk_sys, rst, bipolar_mode, word_load, word_read;
   wire cal_strobe, cal_select_a, cal_select_b, cal_active, cal_midscale, data_ready_n;
   wire cal_zero_from_input, cal_fs_from_input;
   wire [1:0] cal_type;
   int error_cnt, comparisons, n;
   int dur[4] = '{20, 28, 32, 24};
   logic [7:0] rnd = 8'h3D;
   acs_host host(.clk_sys, .cal_strobe, .cal_select_a, .cal_select_b);
   acs_cal_sequencer #(.CYC_SELF(22'h14), .CYC_SYS_OFS(22'h18), .CYC_SYS_GAIN(22'h1C),
      .CYC_OFS_ONE(22'h20), .CYC_SETTLE(22'h10)) dut(.clk_sys, .rst, .cal_strobe,
      .cal_select_a, .cal_select_b, .bipolar_mode, .word_load, .word_read, .cal_active,
      .cal_type, .cal_zero_from_input, .cal_fs_from_input, .cal_midscale, .data_ready_n);
   initial
   begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task results;
      $display("compares %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task step;
      @(posedge clk_sys);
      #1;
   endtask
   task run(input logic [1:0] s);
      @(posedge clk_sys);
      bipolar_mode <= rnd[7];
      rnd <= lfsr(rnd);
      host.cal(s, 4);
      #1;
      for (n = 0; n < 9 && cal_active !== 1'b1; n++) step;
      chk(n, 0);
      chk(cal_type, s);
      chk(cal_midscale, bipolar_mode);
      chk({cal_zero_from_input, cal_fs_from_input}, {s[1], s == 2'h1});
      for (n = 0; n < 99 && cal_active === 1'b1; n++)
      begin
         chk(data_ready_n, 1);
         step;
      end
      chk(n, dur[s]);
      chk(cal_type, s);
      for (n = 0; n < 99 && data_ready_n === 1'b1; n++) step;
      chk(n, s == 2'h0 ? 16 : 0);
   endtask
   initial
   begin
      rst = 1;
      bipolar_mode = 0;
      word_load = 0;
      word_read = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 0;
      host.cal(2'h0, 3);
      repeat (6) step;
      chk(cal_active, 0);
      run(2'h3);
      run(2'h1);
      run(2'h0);
      run(2'h2);
      @(posedge clk_sys) word_load <= 1;
      @(posedge clk_sys) word_load <= 0;
      #1;
      for (n = 0; n < 9 && data_ready_n !== 1'b1; n++) step;
      for (n = 0; n < 9 && data_ready_n === 1'b1; n++) step;
      chk(n, 4);
      @(posedge clk_sys) word_read <= 1;
      @(posedge clk_sys) word_read <= 0;
      step;
      chk(data_ready_n, 1);
      results;
   end
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      error_cnt++;
      results;
   end
endmodule // acs_cal_sequencer_tb
`default_nettype wire

// *** dv/acs_host.sv ***
// host model driving strobe and select pins
`timescale 1ns/1ps
`default_nettype none
module acs_host
(
   // clock
   input wire logic clk_sys,
   // calibration pins
   output logic cal_strobe,
   output logic cal_select_a,
   output logic cal_select_b
);
   initial {cal_strobe, cal_select_a, cal_select_b} = 3'h0;
   task automatic cal(input logic [1:0] s, input int h);
      @(posedge clk_sys);
      {cal_select_a, cal_select_b} <= s;
      cal_strobe <= 1'b1;
      repeat (h) @(posedge clk_sys);
      cal_strobe <= 1'b0;
      @(posedge clk_sys);
      {cal_select_a, cal_select_b} <= ~s;
   endtask
endmodule // acs_host
`default_nettype wire
